// ### shared/wprx_map.svh
// Purpose: offsets, reset values, codes and times of the power receiver
// Assumes: 100 MHz ref_clk, byte addressed register port
// Notes:   definitions only
`ifndef WPRX_MAP_SVH
`define WPRX_MAP_SVH

// ****************************************
// timing
// ****************************************
`define WPRX_CLK_HZ        100000000
`define WPRX_SLOW_MS       250
`define WPRX_FAST_MS       32
`define WPRX_HALF_BIT_US   250

// ****************************************
// register offsets
// ****************************************
`define WPRX_OFF_TOL       8'h00
`define WPRX_OFF_OVS       8'h04
`define WPRX_OFF_TGT0      8'h08
`define WPRX_OFF_STATUS    8'h18
`define WPRX_OFF_INT_STAT  8'h1c
`define WPRX_OFF_INT_MASK  8'h20

// ****************************************
// reset values (millivolts)
// ****************************************
`define WPRX_RST_TOL       16'h0032
`define WPRX_RST_OVS       16'h01f4
`define WPRX_RST_TGT0      16'h1388
`define WPRX_RST_TGT1      16'h13ec
`define WPRX_RST_TGT2      16'h1450
`define WPRX_RST_TGT3      16'h14b4

// ****************************************
// packet headers and end power codes
// ****************************************
`define WPRX_HDR_STRENGTH  8'h01
`define WPRX_HDR_END_POWER 8'h02
`define WPRX_HDR_ERROR     8'h03
`define WPRX_EPT_UNKNOWN   8'h00
`define WPRX_EPT_CHARGED   8'h01
`define WPRX_EPT_OVER_TEMP 8'h03

// interrupt bit positions
`define WPRX_IRQ_EPT       0
`define WPRX_IRQ_CONV      1
`define WPRX_IRQ_OVS       2
`define WPRX_IRQ_LOST      3
`endif

// ### shared/wprx_pkg.sv
// Purpose: shared types of the power receiver control
// Assumes: constants live in wprx_map.svh
// Notes:   one-hot control states
package wprx_pkg;
  typedef logic [7:0] wprx_addr_t;
  typedef enum logic [4:0] {
    ST_WAIT  = 5'b00001,
    ST_IDENT = 5'b00010,
    ST_REG   = 5'b00100,
    ST_POWER = 5'b01000,
    ST_END   = 5'b10000
  } wprx_state_e;
endpackage : wprx_pkg

// ### src/wprx_packet_tx.sv
// Purpose: frames one packet and drives the load modulation level
// Assumes: one start pulse while idle; header and message held by caller
// Notes:   11 preamble ones, three 11-bit bytes, bi-phase coded
`timescale 1ns/1ps
module wprx_packet_tx #(
  parameter int HALF_BIT_CYC = 25000
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic [7:0] hdr,
  input  wire logic [7:0] msg,
  output logic            busy,
  output logic            mod_out
);
  localparam int NBITS = 44;

  logic [NBITS-1:0] frame_reg;
  logic [5:0]       bit_cnt_reg;
  logic             half_reg;
  logic [15:0]      tmr_reg;
  logic [7:0]       chk;

  function automatic logic [10:0] frame_byte(input logic [7:0] d);
    frame_byte = {1'b1, ~^d, d, 1'b0};
  endfunction : frame_byte

  assign chk = hdr ^ msg;

  // ****************************************
  // bi-phase serialiser
  // ****************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy        <= 1'b0;
      mod_out     <= 1'b0;
      frame_reg   <= '0;
      bit_cnt_reg <= 6'h00;
      half_reg    <= 1'b0;
      tmr_reg     <= 16'h0000;
    end else if (!busy) begin
      if (start) begin
        frame_reg   <= {frame_byte(chk), frame_byte(msg), frame_byte(hdr),
                        11'h7ff};
        busy        <= 1'b1;
        mod_out     <= ~mod_out;
        bit_cnt_reg <= 6'h00;
        half_reg    <= 1'b0;
        tmr_reg     <= 16'(HALF_BIT_CYC - 1);
      end
    end else if (tmr_reg != 16'h0000) begin
      tmr_reg <= tmr_reg - 16'h0001;
    end else begin
      tmr_reg <= 16'(HALF_BIT_CYC - 1);
      if (!half_reg) begin
        // a one carries an extra mid-bit transition
        if (frame_reg[0])
          mod_out <= ~mod_out;
        half_reg <= 1'b1;
      end else begin
        half_reg    <= 1'b0;
        frame_reg   <= frame_reg >> 1;
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
        if (bit_cnt_reg == 6'(NBITS - 1)) begin
          busy    <= 1'b0;
          mod_out <= 1'b0;
        end else begin
          mod_out <= ~mod_out;
        end
      end
    end
  end
endmodule : wprx_packet_tx

// ### src/wprx_ctrl.sv
// Purpose: control of an inductive power receiver
// Assumes: register port, rectifier_node_mv and load_band from logic on ref_clk; other inputs are pins
// Notes:   registers at byte offsets of wprx_map.svh, read data one cycle late
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "wprx_map.svh"
module wprx_ctrl #(
  parameter int SLOW_CYC     = `WPRX_SLOW_MS * (`WPRX_CLK_HZ / 1000),
  parameter int FAST_CYC     = `WPRX_FAST_MS * (`WPRX_CLK_HZ / 1000),
  parameter int HALF_BIT_CYC = `WPRX_HALF_BIT_US * (`WPRX_CLK_HZ / 1000000)
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire wprx_pkg::wprx_addr_t reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic                field_present,
  input  wire logic                host_disable_a,
  input  wire logic                host_disable_b,
  input  wire logic                tsc_forced_low,
  input  wire logic                tsc_forced_high,
  input  wire logic [15:0]         rectifier_node_mv,
  input  wire logic [1:0]          load_band,
  output logic                     load_modulation_pins,
  output logic                     ldo_en,
  output logic                     power_active_indicator_n,
  output logic                     irq
);
  import wprx_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end else begin
      pin_meta_reg <= {tsc_forced_high, tsc_forced_low, host_disable_b,
                       host_disable_a, field_present};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic field_on;
  logic dis_both;
  logic tsc_low;
  logic tsc_high;
  logic stop_req;
  logic [7:0] stop_code;
  assign field_on = pin_sync_reg[0];
  // external pulldowns make a floating disable read low
  assign dis_both = pin_sync_reg[1] & pin_sync_reg[2];
  assign tsc_low  = pin_sync_reg[3];
  assign tsc_high = pin_sync_reg[4];
  assign stop_req = dis_both | tsc_low | tsc_high;

  // temperature faults outrank the host's charge complete request
  always_comb begin
    if (tsc_low)
      stop_code = `WPRX_EPT_OVER_TEMP;
    else if (tsc_high)
      stop_code = `WPRX_EPT_UNKNOWN;
    else
      stop_code = `WPRX_EPT_CHARGED;
  end

  // ****************************************
  // software registers
  // ****************************************
  logic [15:0] tol_reg;
  logic [15:0] ovs_reg;
  logic [15:0] tgt_reg [4];
  logic [3:0]  int_stat_reg;
  logic [3:0]  int_mask_reg;
  logic [3:0]  evt;

  function automatic logic hit(input wprx_addr_t a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tol_reg      <= `WPRX_RST_TOL;
      ovs_reg      <= `WPRX_RST_OVS;
      tgt_reg[0]   <= `WPRX_RST_TGT0;
      tgt_reg[1]   <= `WPRX_RST_TGT1;
      tgt_reg[2]   <= `WPRX_RST_TGT2;
      tgt_reg[3]   <= `WPRX_RST_TGT3;
      int_mask_reg <= 4'h0;
    end else if (reg_wr) begin
      if (hit(reg_addr, `WPRX_OFF_TOL))
        tol_reg <= reg_wdata[15:0];
      if (hit(reg_addr, `WPRX_OFF_OVS))
        ovs_reg <= reg_wdata[15:0];
      for (int i = 0; i < 4; i++) begin
        if (hit(reg_addr, 8'(`WPRX_OFF_TGT0 + 4 * i)))
          tgt_reg[i] <= reg_wdata[15:0];
      end
      if (hit(reg_addr, `WPRX_OFF_INT_MASK))
        int_mask_reg <= reg_wdata[3:0];
    end
  end

  // a read clears status; an event in the same cycle still lands
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      int_stat_reg <= 4'h0;
    else if (reg_rd && hit(reg_addr, `WPRX_OFF_INT_STAT))
      int_stat_reg <= evt;
    else
      int_stat_reg <= int_stat_reg | evt;
  end
  assign irq = |(int_stat_reg & int_mask_reg);

  // ****************************************
  // regulation arithmetic
  // ****************************************
  wprx_state_e st_reg;
  logic [1:0]  tgt_idx;
  logic [15:0] tgt_mv;
  logic signed [17:0] diff;
  logic signed [7:0]  err_val;
  logic [17:0] adiff;
  logic        settled;
  logic        overshoot;

  // level one is held until the first convergence
  assign tgt_idx   = (st_reg == ST_POWER) ? load_band : 2'h0;
  assign tgt_mv    = tgt_reg[tgt_idx];
  assign diff      = $signed({2'b00, tgt_mv}) - $signed({2'b00, rectifier_node_mv});
  assign adiff     = diff[17] ? 18'(-diff) : 18'(diff);
  assign settled   = adiff <= {2'b00, tol_reg};
  assign overshoot = diff[17] && (adiff > {2'b00, ovs_reg});

  // control error saturates to the signed byte of the packet
  always_comb begin
    if (diff > 18'sh0007f)
      err_val = 8'sh7f;
    else if (diff < -18'sh00080)
      err_val = 8'sh80;
    else
      err_val = 8'(diff);
  end

  // ****************************************
  // control state machine
  // ****************************************
  logic        field_on_d_reg;
  logic        fast_reg;
  logic [24:0] tmr_reg;
  logic        pkt_go_reg;
  logic [7:0]  pkt_hdr_reg;
  logic [7:0]  pkt_msg_reg;
  logic        pkt_busy;
  logic        pkt_done;
  logic        pkt_busy_d_reg;
  logic        send_err;

  assign pkt_done = pkt_busy_d_reg & ~pkt_busy;
  assign send_err = (tmr_reg == 25'h0) && !pkt_busy && !pkt_go_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      field_on_d_reg <= 1'b0;
      pkt_busy_d_reg <= 1'b0;
    end else begin
      field_on_d_reg <= field_on;
      pkt_busy_d_reg <= pkt_busy;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg      <= ST_WAIT;
      ldo_en      <= 1'b0;
      pkt_go_reg  <= 1'b0;
      pkt_hdr_reg <= 8'h00;
      pkt_msg_reg <= 8'h00;
    end else begin
      pkt_go_reg <= 1'b0;
      if (!field_on && st_reg != ST_WAIT) begin
        st_reg <= ST_WAIT;
        ldo_en <= 1'b0;
      end else begin
        case (st_reg)
          ST_WAIT: begin
            // each new ping is answered, either with a request or a stop
            if (field_on && !pkt_busy) begin
              pkt_go_reg <= 1'b1;
              if (stop_req) begin
                pkt_hdr_reg <= `WPRX_HDR_END_POWER;
                pkt_msg_reg <= stop_code;
                st_reg      <= ST_END;
              end else begin
                pkt_hdr_reg <= `WPRX_HDR_STRENGTH;
                pkt_msg_reg <= rectifier_node_mv[15:8];
                st_reg      <= ST_IDENT;
              end
            end
          end
          ST_IDENT: begin
            if (pkt_done)
              st_reg <= ST_REG;
          end
          ST_REG, ST_POWER: begin
            if (stop_req && !pkt_busy && !pkt_go_reg) begin
              pkt_go_reg  <= 1'b1;
              pkt_hdr_reg <= `WPRX_HDR_END_POWER;
              pkt_msg_reg <= stop_code;
              ldo_en      <= 1'b0;
              st_reg      <= ST_END;
            end else if (st_reg == ST_REG && settled && !stop_req) begin
              ldo_en <= 1'b1;
              st_reg <= ST_POWER;
            end else if (send_err) begin
              pkt_go_reg  <= 1'b1;
              pkt_hdr_reg <= `WPRX_HDR_ERROR;
              pkt_msg_reg <= err_val;
            end
          end
          ST_END: begin
            // stay quiet until the field drops; the next ping restarts
            ldo_en <= 1'b0;
          end
          default: begin
            st_reg <= ST_WAIT;
            ldo_en <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // error packet interval
  // ****************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      fast_reg <= 1'b0;
    else if (st_reg != ST_REG && st_reg != ST_POWER)
      fast_reg <= 1'b0;
    else if (overshoot)
      fast_reg <= 1'b1;
    else if (settled)
      fast_reg <= 1'b0;
  end

  // first error goes out at once after identification
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      tmr_reg <= 25'h0;
    else if (st_reg != ST_REG && st_reg != ST_POWER)
      tmr_reg <= 25'h0;
    else if (overshoot && (pkt_go_reg || tmr_reg > 25'(FAST_CYC - 1)))
      tmr_reg <= 25'(FAST_CYC - 1);
    else if (pkt_go_reg)
      tmr_reg <= fast_reg ? 25'(FAST_CYC - 1) : 25'(SLOW_CYC - 1);
    else if (tmr_reg != 25'h0)
      tmr_reg <= tmr_reg - 25'h1;
  end

  wprx_packet_tx #(
    .HALF_BIT_CYC (HALF_BIT_CYC)
  ) u_pkt (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (pkt_go_reg),
    .hdr     (pkt_hdr_reg),
    .msg     (pkt_msg_reg),
    .busy    (pkt_busy),
    .mod_out (load_modulation_pins)
  );

  // indicator is released whenever the regulator is off
  assign power_active_indicator_n = ~(st_reg == ST_POWER);

  // ****************************************
  // events and read port
  // ****************************************
  assign evt[`WPRX_IRQ_EPT]  = pkt_go_reg &&
                               pkt_hdr_reg == `WPRX_HDR_END_POWER;
  assign evt[`WPRX_IRQ_CONV] = st_reg == ST_REG && settled && !stop_req &&
                               field_on;
  assign evt[`WPRX_IRQ_OVS]  = overshoot && !fast_reg &&
                               (st_reg == ST_REG || st_reg == ST_POWER);
  assign evt[`WPRX_IRQ_LOST] = field_on_d_reg && !field_on;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (hit(reg_addr, `WPRX_OFF_TOL))
        reg_rdata <= {16'h0, tol_reg};
      else if (hit(reg_addr, `WPRX_OFF_OVS))
        reg_rdata <= {16'h0, ovs_reg};
      else if (reg_addr[7:5] == 3'h0 && reg_addr[4:3] != 2'h0 &&
               reg_addr[1:0] == 2'h0 && !hit(reg_addr, `WPRX_OFF_STATUS) &&
               !hit(reg_addr, `WPRX_OFF_INT_STAT))
        reg_rdata <= {16'h0, tgt_reg[2'(reg_addr[4:2] - 3'h2)]};
      else if (hit(reg_addr, `WPRX_OFF_STATUS))
        reg_rdata <= {20'h0, tgt_idx, fast_reg, ~power_active_indicator_n,
                      ldo_en, st_reg, pkt_busy, field_on};
      else if (hit(reg_addr, `WPRX_OFF_INT_STAT))
        reg_rdata <= {28'h0, int_stat_reg};
      else if (hit(reg_addr, `WPRX_OFF_INT_MASK))
        reg_rdata <= {28'h0, int_mask_reg};
      else
        reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_ident_first: assert property (
    (st_reg == ST_WAIT && field_on && !pkt_busy && !stop_req)
    |=> st_reg == ST_IDENT && pkt_go_reg ##1 pkt_busy)
    else $error("identification not started on a fresh field");
  a_err_track: assert property (
    (pkt_go_reg && pkt_hdr_reg == `WPRX_HDR_ERROR)
    |-> $past(st_reg == ST_REG || st_reg == ST_POWER))
    else $error("error packet sent outside regulation");
  a_slow_bound: assert property (
    tmr_reg <= 25'(SLOW_CYC - 1))
    else $error("error interval beyond the slow period");
  a_fast_entry: assert property (
    (overshoot && field_on && !stop_req && st_reg == ST_POWER)
    |=> fast_reg && tmr_reg <= 25'(FAST_CYC - 1))
    else $error("overshoot did not shorten the interval");
  a_first_level: assert property (
    st_reg == ST_REG |-> tgt_idx == 2'h0)
    else $error("start-up target is not level one");
  a_ldo_gate: assert property (
    $rose(ldo_en) |-> $past(st_reg == ST_REG && settled))
    else $error("regulator enabled before convergence");
  a_charged_code: assert property (
    (st_reg == ST_POWER && field_on && dis_both && !tsc_low && !tsc_high
     && !pkt_busy && !pkt_go_reg)
    |=> pkt_go_reg && pkt_msg_reg == `WPRX_EPT_CHARGED && !ldo_en)
    else $error("charge complete not sent");
  a_ping_resend: assert property (
    (st_reg == ST_WAIT && field_on && !pkt_busy && dis_both)
    |=> st_reg == ST_END && pkt_hdr_reg == `WPRX_HDR_END_POWER)
    else $error("ping not answered with end power");
  a_ind_follow: assert property (
    !ldo_en |-> power_active_indicator_n)
    else $error("indicator active without transfer");
  a_temp_code: assert property (
    (st_reg == ST_POWER && field_on && tsc_low && !pkt_busy && !pkt_go_reg)
    |=> pkt_msg_reg == `WPRX_EPT_OVER_TEMP ##1 st_reg == ST_END)
    else $error("over temperature code not sent");

  c_power_up: cover property ($rose(ldo_en));
  c_charged: cover property (
    st_reg == ST_POWER ##1 st_reg == ST_END);
  c_fast: cover property ($rose(fast_reg));
endmodule : wprx_ctrl

// ### tb/wprx_txm.sv
// Purpose: transmitter side model: pings, decodes packets, gates field
// Assumes: bi-phase packets of 44 bits, HB cycles a half bit
// Notes:   field drops on end power or on a missing identification
`timescale 1ns/1ps
`include "wprx_map.svh"
module wprx_txm #(
  parameter int HB  = 4,
  parameter int IDW = 1500
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        load_modulation_pins,
  input  wire logic [15:0] gap_cyc,
  output logic             field_present,
  output int               pkt_cnt,
  output int               pkt_t,
  output logic [7:0]       pkt_hdr,
  output logic [7:0]       pkt_msg,
  output logic             pkt_ok
);
  // ****************************************
  // decode and field control
  // ****************************************
  logic [87:0] s;
  logic [43:0] b;
  logic        prev, rx, pwr;
  int          n, idle, cyc;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      field_present <= 1'b0;
      pkt_cnt <= 0;
      pkt_t <= 0;
      pkt_hdr <= 8'h00;
      pkt_msg <= 8'h00;
      pkt_ok <= 1'b0;
      prev = 1'b0;
      rx = 1'b0;
      pwr = 1'b0;
      n = 0;
      idle = 0;
      cyc = 0;
    end else begin
      cyc++;
      idle++;
      // only a rise starts a packet: the fall back to idle is no start
      if (!rx && !prev && load_modulation_pins) begin
        rx = 1'b1;
        n = 0;
        pkt_t <= cyc;
      end
      if (rx) begin
        if (n % HB == 1)
          s[n / HB] = load_modulation_pins;
        n++;
      end
      prev = load_modulation_pins;
      if (!field_present && idle >= int'(gap_cyc)) begin
        field_present <= 1'b1;
        idle = 0;
        pwr = 1'b0;
      end
      if (field_present && !pwr && !rx && idle >= IDW) begin
        field_present <= 1'b0;
        idle = 0;
      end
      if (rx && n == 88 * HB) begin
        rx = 1'b0;
        for (int j = 0; j < 44; j++)
          b[j] = s[2*j] ^ s[2*j+1];
        pkt_hdr <= b[19:12];
        pkt_msg <= b[30:23];
        pkt_ok <= &b[10:0] && !b[11] && ^b[20:12] && b[21] && !b[22]
          && ^b[31:23] && b[32] && !b[33] && ^b[42:34] && b[43]
          && b[41:34] == (b[19:12] ^ b[30:23]);
        pkt_cnt <= pkt_cnt + 1;
        if (b[19:12] == `WPRX_HDR_STRENGTH)
          pwr = 1'b1;
        if (b[19:12] == `WPRX_HDR_END_POWER) begin
          field_present <= 1'b0;
          pwr = 1'b0;
          idle = 0;
        end
      end
    end
  end
endmodule : wprx_txm

// ### tb/tb.sv
// Purpose: self-checking bench of the power receiver control
// Assumes: shortened counts, transmitter model on the coil link
// Notes:   seeded random levels and ping gaps
`timescale 1ns/1ps
`include "wprx_map.svh"
module tb;
  import wprx_pkg::*;
  localparam int SLOW = 2000;
  localparam int FAST = 600;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, field_present, pkt_ok;
  logic        host_disable_a, host_disable_b, tsc_forced_low, irq;
  logic        tsc_forced_high, load_modulation_pins, ldo_en;
  logic        power_active_indicator_n;
  wprx_addr_t  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] rectifier_node_mv, gap_cyc;
  logic [7:0]  pkt_hdr, pkt_msg;
  logic [1:0]  load_band;
  int          pkt_cnt, pkt_t, t0, miscompares, samples_checked, seed;
  logic [15:0] tg [4];
  logic [7:0]  cd [3];
  logic [7:0]  offs [8];
  logic [31:0] rv [8];

  wprx_ctrl #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .HALF_BIT_CYC(4)) uut (
    .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .field_present, .host_disable_a, .host_disable_b,
    .tsc_forced_low, .tsc_forced_high, .rectifier_node_mv, .load_band,
    .load_modulation_pins, .ldo_en, .power_active_indicator_n, .irq);
  wprx_txm #(.HB(4), .IDW(1500)) txm (
    .ref_clk, .sys_rst, .load_modulation_pins, .gap_cyc, .field_present,
    .pkt_cnt, .pkt_t, .pkt_hdr, .pkt_msg, .pkt_ok);

  // ****************************************
  // helpers
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  function automatic logic [7:0] err_exp(input logic [15:0] t, r);
    int e;
    e = int'(t) - int'(r);
    e = (e > 127) ? 127 : (e < -128) ? -128 : e;
    return 8'(e);
  endfunction : err_exp

  task automatic wait_pkt(input logic [7:0] h, m);
    int c;
    c = pkt_cnt;
    for (int i = 0; i < 20000 && pkt_cnt == c; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (pkt_cnt == c) begin
      chk("pkt_wait", 1, 0);
      give_verdict();
    end
    chk("pkt_hdr", h, pkt_hdr);
    chk("pkt_msg", m, pkt_msg);
    chk("pkt_frame", 1, pkt_ok);
  endtask : wait_pkt

  task automatic power_up;
    logic [15:0] r;
    r = tg[0] - 16'(100 + ($random(seed) & 255));
    @(posedge ref_clk);
    rectifier_node_mv <= r;
    gap_cyc <= 16'(200 + ($random(seed) & 255));
    wait_pkt(`WPRX_HDR_STRENGTH, r[15:8]);
    wait_pkt(`WPRX_HDR_ERROR, err_exp(tg[0], r));
    chk("ldo_hold", 0, ldo_en);
    chk("ind_off", 1, power_active_indicator_n);
    @(posedge ref_clk);
    rectifier_node_mv <= tg[0] + 16'($random(seed) % 50);
    for (int i = 0; i < 6000 && ldo_en !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("ldo_on", 1, ldo_en);
    if (ldo_en !== 1'b1)
      give_verdict();
    chk("ind_on", 0, power_active_indicator_n);
    $display("power up done");
  endtask : power_up

  task automatic steady;
    logic r;
    r = 1'($random(seed));
    @(posedge ref_clk);
    host_disable_a <= r;
    host_disable_b <= !r;
    wait_pkt(`WPRX_HDR_ERROR, err_exp(tg[0], rectifier_node_mv));
    t0 = pkt_t;
    wait_pkt(`WPRX_HDR_ERROR, err_exp(tg[0], rectifier_node_mv));
    chk("slow_gap", 1, (pkt_t - t0) inside {[SLOW-3:SLOW+3]});
    chk("ldo_one_dis", 1, ldo_en);
  endtask : steady

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    seed = 41;
    miscompares = 0;
    samples_checked = 0;
    tg = '{`WPRX_RST_TGT0, `WPRX_RST_TGT1, `WPRX_RST_TGT2, `WPRX_RST_TGT3};
    cd = '{`WPRX_EPT_CHARGED, `WPRX_EPT_OVER_TEMP, `WPRX_EPT_UNKNOWN};
    offs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
    rv = '{`WPRX_RST_TOL, `WPRX_RST_OVS, tg[0], tg[1], tg[2], tg[3], 0, 0};
    {sys_rst, reg_wr, reg_rd, host_disable_a, host_disable_b} = 5'h10;
    tsc_forced_low = 1'b0;
    tsc_forced_high = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    load_band = 2'h0;
    rectifier_node_mv = 16'h0;
    gap_cyc = 16'(200 + ($random(seed) & 255));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk("reg_reset", rv[i], d);
    end
    d = 32'($random(seed)) & 32'hf;
    wr(`WPRX_OFF_INT_MASK, d);
    rd(`WPRX_OFF_INT_MASK, rv[0]);
    chk("mask_rw", d, rv[0]);
    wr(8'h28, 32'($random(seed)));
    rd(8'h28, d);
    chk("unmapped", 0, d);
    wr(`WPRX_OFF_INT_MASK, 32'h0);
    $display("registers done");
    power_up();
    chk("irq_masked", 0, irq);
    rd(`WPRX_OFF_INT_STAT, d);
    chk("conv_event", 1, d[`WPRX_IRQ_CONV]);
    steady();
    for (int k = 3; k >= 0; k--) begin
      @(posedge ref_clk);
      load_band <= 2'(k);
      wait_pkt(`WPRX_HDR_ERROR, err_exp(tg[k], rectifier_node_mv));
      rd(`WPRX_OFF_STATUS, d);
      chk("tgt_idx", k, d[11:10]);
      chk("status", 7'h68, d[8:2]);
    end
    $display("load levels done");
    wr(`WPRX_OFF_INT_MASK, 32'h1 << `WPRX_IRQ_OVS);
    @(posedge ref_clk);
    rectifier_node_mv <= tg[0] + `WPRX_RST_OVS + 16'h1;
    wait_pkt(`WPRX_HDR_ERROR, 8'h80);
    chk("irq_ovs", 1, irq);
    t0 = pkt_t;
    wait_pkt(`WPRX_HDR_ERROR, 8'h80);
    chk("fast_gap", 1, (pkt_t - t0) inside {[FAST-3:FAST+3]});
    rd(`WPRX_OFF_STATUS, d);
    chk("fast_on", 1, d[9]);
    @(posedge ref_clk);
    rectifier_node_mv <= tg[0];
    wait_pkt(`WPRX_HDR_ERROR, 8'h00);
    wait_pkt(`WPRX_HDR_ERROR, 8'h00);
    rd(`WPRX_OFF_STATUS, d);
    chk("fast_off", 0, d[9]);
    rd(`WPRX_OFF_INT_STAT, d);
    chk("ovs_event", 1, d[`WPRX_IRQ_OVS]);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_clear", 0, irq);
    $display("overshoot done");
    for (int k = 0; k < 3; k++) begin
      steady();
      @(posedge ref_clk);
      {host_disable_a, host_disable_b} <= {2{k == 0}};
      {tsc_forced_low, tsc_forced_high} <= {k == 1, k == 2};
      wait_pkt(`WPRX_HDR_END_POWER, cd[k]);
      chk("ldo_stop", 0, ldo_en);
      chk("ind_stop", 1, power_active_indicator_n);
      wait_pkt(`WPRX_HDR_END_POWER, cd[k]);
      rd(`WPRX_OFF_INT_STAT, d);
      chk("ept_lost_events", 32'h9, d & 32'h9);
      @(posedge ref_clk);
      {host_disable_a, host_disable_b} <= 2'h0;
      {tsc_forced_low, tsc_forced_high} <= 2'h0;
      power_up();
      $display("stop case %0d done", k);
    end
    give_verdict();
  end
endmodule : tb
